// ==== iepf_map.svh ====
/*
  Register offsets, field positions and reset values of the interrupt
  enable and pin flag block.
  Assumes: included by bare name from the block.
*/
`ifndef IEPF_MAP_SVH
`define IEPF_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IEPF_OFF_ENABLE_FIRST 8'h00
`define IEPF_OFF_ENABLE_SECOND 8'h01
`define IEPF_OFF_PIN_FLAGS 8'h02
`define IEPF_OFF_PIN_EDGE_SELECT 8'h03
`define IEPF_OFF_PIN_FUNCTION 8'h04

// ----------------------------------------------------------------
// Field positions, first enable register
// ----------------------------------------------------------------
`define IEPF_BIT_RTC 7
`define IEPF_BIT_RESV_FIRST 6
`define IEPF_BIT_WAKEUP 5

// ----------------------------------------------------------------
// Reset values and fixed read bits
// ----------------------------------------------------------------
`define IEPF_RST_ENABLE_FIRST 8'h40
`define IEPF_RST_ENABLE_SECOND 8'h00
`define IEPF_RST_FLAGS 5'h00
`define IEPF_RST_EDGE 5'h00
`define IEPF_RST_FUNCTION 5'h00
`define IEPF_FIRST_FIXED_MASK 8'h40
`define IEPF_FLAGS_RESV_ONES 3'h7
`define IEPF_READ_UNMAPPED 8'h00

`endif

// ==== iepf_pkg.sv ====
/*
  Types shared by the interrupt enable and pin flag block.
  Assumes: nothing beyond the map header.
*/
package iepf_pkg;
  // Register data byte
  typedef logic [7:0] iepf_byte_t;
  // One bit per external pin: 4, 3, event, 1, 0 at bits 4..0
  typedef logic [4:0] iepf_pins_t;
  // Eight wakeup pins
  typedef logic [7:0] iepf_wake_t;
endpackage : iepf_pkg

// ==== iepf_ctrl.sv ====
/*
  Interrupt enable registers and external pin request flags.
  Assumes: pins and requests are synchronous to ref_clk_in; the CPU
  reaches the registers with one-cycle strobes and reads data one
  cycle after the read strobe.
*/
`include "iepf_map.svh"

// Functional notes
// RULE1 - First bit 7 gates real-time-clock request
// RULE2 - First bit 6 reads one, ignores writes
// RULE3 - First bit 5 enables all wakeup requests
// RULE4 - First bit 4 enables pin 4
// RULE5 - First bit 3 enables pin 3
// RULE6 - First bit 2 enables event pin
// RULE7 - First bit 1 enables pin 1
// RULE8 - First bit 0 enables pin 0
// RULE9 - Second bit 7 enables direct transition
// RULE10 - Second bit 6 enables conversion done
// RULE11 - Second bit 5 plain storage bit
// RULE12 - Second bit 4 enables timer G
// RULE13 - Second bit 3 enables timer F high
// RULE14 - Second bit 2 enables timer F low
// RULE15 - Second bits 1,0 timer C, event counter
// RULE16 - Flag bits 7 to 5 read one
// RULE17 - One flag per pin, reset zero
// RULE18 - Flag set on selected edge when enabled
// RULE19 - Writing zero clears, one leaves unchanged
// RULE20 - Event pin flag follows same rule
// RULE21 - Edge select zero falling, one rising
// RULE22 - Request out only when flag and enable
module iepf_ctrl (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire iepf_pkg::iepf_byte_t addr_in,
  input wire iepf_pkg::iepf_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output iepf_pkg::iepf_byte_t rdata_out,
  // External pins
  input wire logic ext_pin_4_in,
  input wire logic ext_pin_3_in,
  input wire logic event_counter_pin_in,
  input wire logic ext_pin_1_in,
  input wire logic ext_pin_0_in,
  // Requests from other sources
  input wire logic rtc_req_in,
  input wire iepf_pkg::iepf_wake_t wakeup_pins_req_in,
  input wire logic direct_transition_req_in,
  input wire logic conversion_done_req_in,
  input wire logic timer_g_req_in,
  input wire logic timer_f_high_req_in,
  input wire logic timer_f_low_req_in,
  input wire logic timer_c_req_in,
  input wire logic event_counter_req_in,
  // Gated requests to the CPU
  output logic rtc_irq_out,
  output iepf_pkg::iepf_wake_t wakeup_irq_out,
  output logic ext4_irq_out,
  output logic ext3_irq_out,
  output logic event_pin_irq_out,
  output logic ext1_irq_out,
  output logic ext0_irq_out,
  output iepf_pkg::iepf_byte_t second_irq_out
);
  import iepf_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Address match for a strobe
  function automatic logic reg_hit(input iepf_byte_t a, input iepf_byte_t off);
    reg_hit = (a == off);
  endfunction

  // Rising or falling edge chosen per pin
  function automatic iepf_pins_t pick_edge(input iepf_pins_t cur, input iepf_pins_t old,
                                            input iepf_pins_t sel);
    pick_edge = (sel & cur & ~old) | (~sel & ~cur & old);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iepf_byte_t interrupt_enable_first; // Bit 6 held at one
  iepf_byte_t interrupt_enable_second; // All bits plain storage
  iepf_pins_t pin_request_flags; // Pin flags
  iepf_pins_t pin_edge_select; // 1 rising, 0 falling
  iepf_pins_t pin_function; // 1 pin used as interrupt input
  iepf_pins_t pin_prev; // Pin level one cycle back
  logic pin_primed; // Pin history valid
  iepf_pins_t ext_irq; // Gated pin requests
  iepf_byte_t rdata; // Read data register

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire logic act = ce_in;
  wire logic wr_first = act & wr_in & reg_hit(addr_in, `IEPF_OFF_ENABLE_FIRST);
  wire logic wr_second = act & wr_in & reg_hit(addr_in, `IEPF_OFF_ENABLE_SECOND);
  wire logic wr_flags = act & wr_in & reg_hit(addr_in, `IEPF_OFF_PIN_FLAGS);
  wire logic wr_edge = act & wr_in & reg_hit(addr_in, `IEPF_OFF_PIN_EDGE_SELECT);
  wire logic wr_func = act & wr_in & reg_hit(addr_in, `IEPF_OFF_PIN_FUNCTION);
  // Pins gathered in flag bit order
  wire iepf_pins_t pins_now = {ext_pin_4_in, ext_pin_3_in, event_counter_pin_in,
                               ext_pin_1_in, ext_pin_0_in};
  // RULE21 edge choice
  wire iepf_pins_t edge_seen = pick_edge(pins_now, pin_prev, pin_edge_select);
  // RULE18 set only on selected edge of an interrupt pin
  // RULE20 event pin is bit 2, same terms
  wire iepf_pins_t flag_set = pin_primed ? (edge_seen & pin_function) : 5'h00;
  // RULE19 only written zeros clear
  wire iepf_pins_t flag_clr = wr_flags ? ~wdata_in[4:0] : 5'h00;
  // Set wins over a clear in the same cycle
  wire iepf_pins_t next_flags = (pin_request_flags & ~flag_clr) | flag_set;
  // RULE2 bit 6 forced to one
  wire iepf_byte_t next_first = wdata_in | `IEPF_FIRST_FIXED_MASK;
  // Read selection
  // RULE16 flag bits 7..5 read one
  wire iepf_byte_t read_mux =
    reg_hit(addr_in, `IEPF_OFF_ENABLE_FIRST) ? interrupt_enable_first :
    reg_hit(addr_in, `IEPF_OFF_ENABLE_SECOND) ? interrupt_enable_second :
    reg_hit(addr_in, `IEPF_OFF_PIN_FLAGS) ? {`IEPF_FLAGS_RESV_ONES, pin_request_flags} :
    reg_hit(addr_in, `IEPF_OFF_PIN_EDGE_SELECT) ? {3'h0, pin_edge_select} :
    reg_hit(addr_in, `IEPF_OFF_PIN_FUNCTION) ? {3'h0, pin_function} :
    `IEPF_READ_UNMAPPED;
  // RULE4 RULE5 RULE6 RULE7 RULE8 pin enables are first bits 4..0
  // RULE22 request only with flag and enable
  wire iepf_pins_t next_ext_irq = pin_request_flags & interrupt_enable_first[4:0];
  // RULE9 RULE10 RULE12 RULE13 RULE14 RULE15 gated bit for bit
  // RULE11 bit 5 has no source, its output stays zero
  wire iepf_byte_t second_reqs = {direct_transition_req_in, conversion_done_req_in, 1'b0,
                                  timer_g_req_in, timer_f_high_req_in, timer_f_low_req_in,
                                  timer_c_req_in, event_counter_req_in};
  wire iepf_byte_t next_second_irq = second_reqs & interrupt_enable_second;

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------

  // First and second enables
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Reset values
      interrupt_enable_first <= `IEPF_RST_ENABLE_FIRST;
      interrupt_enable_second <= `IEPF_RST_ENABLE_SECOND;
    end else begin
      // Writes from the register port
      // RULE2 fixed bit via mask
      if (wr_first) begin
        interrupt_enable_first <= next_first;
      end
      // RULE11 plain storage
      if (wr_second) begin
        interrupt_enable_second <= wdata_in;
      end
    end
  end

  // Edge select and pin function
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Reset values
      pin_edge_select <= `IEPF_RST_EDGE;
      pin_function <= `IEPF_RST_FUNCTION;
    end else begin
      // Edge select and function writes
      // RULE21 selection store
      if (wr_edge) begin
        pin_edge_select <= wdata_in[4:0];
      end
      if (wr_func) begin
        pin_function <= wdata_in[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin history and flags
  // ----------------------------------------------------------------

  // Pin levels and flags
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Reset values, history unprimed
      pin_prev <= 5'h00;
      pin_primed <= 1'b0;
      pin_request_flags <= `IEPF_RST_FLAGS;
    end else if (act) begin
      // Sample pins, update flags
      pin_prev <= pins_now;
      pin_primed <= 1'b1;
      // RULE17 one flag per pin
      pin_request_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Read data and gated requests
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Reset values
      rdata <= 8'h00;
      ext_irq <= 5'h00;
      rtc_irq_out <= 1'b0;
      wakeup_irq_out <= 8'h00;
      second_irq_out <= 8'h00;
    end else if (act) begin
      // Gate requests, drive read data
      // Data stand only in the cycle after the strobe
      rdata <= rd_in ? read_mux : 8'h00;
      ext_irq <= next_ext_irq;
      // RULE1 real-time-clock gate
      rtc_irq_out <= rtc_req_in & interrupt_enable_first[`IEPF_BIT_RTC];
      // RULE3 one shared wakeup enable
      wakeup_irq_out <= wakeup_pins_req_in & {8{interrupt_enable_first[`IEPF_BIT_WAKEUP]}};
      second_irq_out <= next_second_irq;
    end
  end

  // Port mapping of flop bits
  assign rdata_out = rdata;
  assign ext4_irq_out = ext_irq[4];
  assign ext3_irq_out = ext_irq[3];
  assign event_pin_irq_out = ext_irq[2];
  assign ext1_irq_out = ext_irq[1];
  assign ext0_irq_out = ext_irq[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  rtc_gate_a: assert property ( // RULE1
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> rtc_irq_out == $past(rtc_req_in & interrupt_enable_first[7]))
    else $error("rtc request not gated by enable");

  first_resv_a: assert property ( // RULE2
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && rd_in && addr_in == `IEPF_OFF_ENABLE_FIRST |=> rdata_out[6])
    else $error("reserved first bit read zero");

  wake_gate_a: assert property ( // RULE3
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> wakeup_irq_out ==
      $past(wakeup_pins_req_in & {8{interrupt_enable_first[5]}}))
    else $error("wakeup requests not gated");

  second_store_a: assert property ( // RULE11
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && wr_in && addr_in == `IEPF_OFF_ENABLE_SECOND
      |=> interrupt_enable_second == $past(wdata_in))
    else $error("second enable write lost");

  flags_resv_a: assert property ( // RULE16
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && rd_in && addr_in == `IEPF_OFF_PIN_FLAGS |=> rdata_out[7:5] == 3'h7)
    else $error("reserved flag bits not one");

  flag_edge_a: assert property ( // RULE18
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in ##1 ce_in |=> (pin_request_flags & $past(flag_set)) == $past(flag_set))
    else $error("selected edge did not set flag");

  no_sw_set_a: assert property ( // RULE19
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && flag_set == 5'h00 |=>
      (pin_request_flags & ~$past(pin_request_flags)) == 5'h00)
    else $error("flag set without an edge");

  pin_gate_a: assert property ( // RULE22
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> ext_irq == $past(pin_request_flags & interrupt_enable_first[4:0]))
    else $error("pin request not gated by flag and enable");

  read_idle_a: assert property ( // RULE17
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read slot");

  // Second requests against their enables
  second_gate_a: assert property ( // RULE9
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> second_irq_out == ($past(interrupt_enable_second) &
      $past({direct_transition_req_in, conversion_done_req_in, 1'b0, timer_g_req_in,
      timer_f_high_req_in, timer_f_low_req_in, timer_c_req_in, event_counter_req_in})))
    else $error("second requests not gated by enables");

  // Reserved second bit drives no request
  second_resv_a: assert property ( // RULE11
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> !second_irq_out[5])
    else $error("reserved second request bit driven");

  // Pin enables store as written
  first_write_a: assert property ( // RULE4
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && wr_in && addr_in == `IEPF_OFF_ENABLE_FIRST
      |=> interrupt_enable_first == ($past(wdata_in) | `IEPF_FIRST_FIXED_MASK))
    else $error("first enable write lost");

  // Written zeros clear, ones keep
  flag_clear_a: assert property ( // RULE19
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && wr_in && addr_in == `IEPF_OFF_PIN_FLAGS && flag_set == 5'h00
      |=> pin_request_flags == ($past(pin_request_flags) & $past(wdata_in[4:0])))
    else $error("flag write did not clear as written");

  // No flag on a pin outside interrupt use
  func_gate_a: assert property ( // RULE18
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in |=> (pin_request_flags & ~$past(pin_request_flags) & ~$past(pin_function)) == 5'h00)
    else $error("flag set on a pin not used for interrupts");

  // Event pin rising edge sets its flag
  event_rise_a: assert property ( // RULE20
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && pin_primed && pin_function[2] && pin_edge_select[2] && event_counter_pin_in &&
      !pin_prev[2] |=> pin_request_flags[2])
    else $error("event pin edge did not set flag");

  // Falling edge selected by a zero
  fall_set_a: assert property ( // RULE21
    @(posedge ref_clk_in) disable iff (rst_in)
    ce_in && pin_primed && pin_function[3] && !pin_edge_select[3] && !ext_pin_3_in &&
      pin_prev[3] |=> pin_request_flags[3])
    else $error("falling edge did not set flag");

  // Reset loads the documented values
  reset_vals_a: assert property ( // RULE17
    @(posedge ref_clk_in)
    rst_in |=> interrupt_enable_first == `IEPF_RST_ENABLE_FIRST &&
      interrupt_enable_second == 8'h00 && pin_request_flags == 5'h00 && rdata_out == 8'h00)
    else $error("reset values not loaded");

  // Low clock enable freezes state
  ce_freeze_a: assert property ( // RULE17
    @(posedge ref_clk_in) disable iff (rst_in)
    !ce_in |=> $stable(pin_request_flags) && $stable(interrupt_enable_second) &&
      $stable(rdata_out))
    else $error("state moved while clock enable low");

endmodule // iepf_ctrl

// ==== iepf_far.sv ====
/*
  Far-side model: external pins and on-chip request sources.
  Assumes: the bench commands levels; the model launches them just
  after each rising edge and holds them for the whole cycle.
*/
module iepf_far (
  // Clock
  input wire logic ref_clk_in,
  // Commands from the bench
  input wire iepf_pkg::iepf_pins_t pin_cmd_in,
  input wire logic [16:0] req_cmd_in,
  // Levels toward the block
  output iepf_pkg::iepf_pins_t pins_out,
  output logic [16:0] reqs_out
);
  import iepf_pkg::*;
  // Launch after the edge so the block samples a stable level
  always_ff @(posedge ref_clk_in) begin
    pins_out <= pin_cmd_in;
    reqs_out <= req_cmd_in;
  end
endmodule // iepf_far

// ==== iepf_tb.sv ====
/*
  Self-checking bench of the enable registers and pin request flags.
  Assumes: the map offsets of the block and the far-side model.
*/
module iepf_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iepf_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, wr = 1'b0, rd = 1'b0;
  iepf_byte_t addr = 8'h00, wdata = 8'h00, rdata, sec_irq;
  iepf_pins_t pin_cmd = 5'h00, pins, irqs;
  logic [16:0] req_cmd = 17'h00000, reqs;
  iepf_wake_t wake_irq;
  logic rtc_irq;
  int miscompares = 0, checked = 0;
  // Rows: address, written value, value read back
  iepf_byte_t rows [8][3] = '{'{8'h00, 8'hFF, 8'hFF}, '{8'h00, 8'h00, 8'h40},
    '{8'h00, 8'hA5, 8'hE5}, '{8'h01, 8'hFF, 8'hFF}, '{8'h01, 8'h20, 8'h20},
    '{8'h02, 8'hFF, 8'hE0}, '{8'h03, 8'hFF, 8'h1F}, '{8'h07, 8'hFF, 8'h00}};
  // Free-running clock
  always #5 ref_clk_in = ~ref_clk_in;
  iepf_far u_iepf_far (.ref_clk_in(ref_clk_in), .pin_cmd_in(pin_cmd),
    .req_cmd_in(req_cmd), .pins_out(pins), .reqs_out(reqs));
  iepf_ctrl u_iepf_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .ext_pin_4_in(pins[4]), .ext_pin_3_in(pins[3]), .event_counter_pin_in(pins[2]),
    .ext_pin_1_in(pins[1]), .ext_pin_0_in(pins[0]), .rtc_req_in(reqs[16]),
    .wakeup_pins_req_in(reqs[15:8]), .direct_transition_req_in(reqs[7]),
    .conversion_done_req_in(reqs[6]), .timer_g_req_in(reqs[4]),
    .timer_f_high_req_in(reqs[3]), .timer_f_low_req_in(reqs[2]),
    .timer_c_req_in(reqs[1]), .event_counter_req_in(reqs[0]),
    .rtc_irq_out(rtc_irq), .wakeup_irq_out(wake_irq), .ext4_irq_out(irqs[4]),
    .ext3_irq_out(irqs[3]), .event_pin_irq_out(irqs[2]), .ext1_irq_out(irqs[1]),
    .ext0_irq_out(irqs[0]), .second_irq_out(sec_irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Byte compare, counted
  task automatic chk(input iepf_byte_t got, input iepf_byte_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input iepf_byte_t a, input iepf_byte_t d);
    @(posedge ref_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data checked in the following cycle
  task automatic rd_chk(input iepf_byte_t a, input iepf_byte_t exp);
    @(posedge ref_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Lets the far-side launch, flag and output stages land
  task automatic settle;
    repeat (4) @(posedge ref_clk_in);
    #1;
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(8'h00, 8'h40);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'hE0);
    @(posedge ref_clk_in);
    #1 chk(rdata, 8'h00);
    $display("test reset done");
    // Table rows: write then read back
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i][0], rows[i][1]);
      rd_chk(rows[i][0], rows[i][2]);
    end
    $display("test table done");
    // Source requests gated by enables
    wr_reg(8'h01, 8'hFF);
    wr_reg(8'h00, 8'hA0);
    req_cmd <= 17'h1FFFF;
    settle;
    chk(sec_irq, 8'hDF);
    chk({7'h00, rtc_irq}, 8'h01);
    chk(wake_irq, 8'hFF);
    wr_reg(8'h01, 8'h81);
    wr_reg(8'h00, 8'h00);
    settle;
    chk(sec_irq, 8'h81);
    chk({7'h00, rtc_irq}, 8'h00);
    chk(wake_irq, 8'h00);
    wr_reg(8'h01, 8'h5A);
    settle;
    chk(sec_irq, 8'h5A);
    req_cmd <= 17'h00000;
    settle;
    chk(sec_irq, 8'h00);
    $display("test gating done");
    // Pin edges: rising on 4, event, 0; falling on 3, 1
    wr_reg(8'h04, 8'h1F);
    wr_reg(8'h03, 8'h15);
    wr_reg(8'h00, 8'h1F);
    pin_cmd <= 5'h1F;
    settle;
    rd_chk(8'h02, 8'hF5);
    chk({3'h0, irqs}, 8'h15);
    wr_reg(8'h02, 8'hFB);
    rd_chk(8'h02, 8'hF1);
    pin_cmd <= 5'h00;
    settle;
    rd_chk(8'h02, 8'hFB);
    chk({3'h0, irqs}, 8'h1B);
    // Pins not set as interrupt inputs
    wr_reg(8'h02, 8'hE0);
    wr_reg(8'h04, 8'h00);
    pin_cmd <= 5'h1F;
    settle;
    pin_cmd <= 5'h00;
    settle;
    rd_chk(8'h02, 8'hE0);
    chk({3'h0, irqs}, 8'h00);
    $display("test pins done");
    // Held clock enable drops a write
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    wr_reg(8'h01, 8'h00);
    ce_in <= 1'b1;
    rd_chk(8'h01, 8'h5A);
    // Second reset in mid-run
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(8'h00, 8'h40);
    rd_chk(8'h01, 8'h00);
    $display("test awkward done");
    wrap_up;
  end
  // Watchdog far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    wrap_up;
  end
endmodule // iepf_tb
